// File: shared/cscw_map.svh
// register indices, field positions and reset values of the socket block
// included by the design; definitions only
`ifndef CSCW_MAP_SVH
`define CSCW_MAP_SVH

// register indices inside one socket, and the two socket bases
`define CSCW_IDX_STATUS 8'h04
`define CSCW_IDX_CONFIG 8'h05
`define CSCW_IDX_WIN_EN 8'h06
`define CSCW_IDX_IO_CTRL 8'h07
`define CSCW_SOCK_A_BASE 8'h00
`define CSCW_SOCK_B_BASE 8'h40
// memory-mapped alias: socket memory base plus this, plus the index
`define CSCW_MEM_ALIAS 4'h8

// status-change configuration fields
`define CSCW_SEL_MSB 7
`define CSCW_SEL_LSB 4
`define CSCW_SRC_CD 3
`define CSCW_SRC_READY 2
`define CSCW_SRC_BATWARN 1
`define CSCW_SRC_BATDEAD 0
`define CSCW_SEL_NONE 4'h0
`define CSCW_SEL_IRQ1 4'h1
`define CSCW_SEL_SMI 4'h2

// window enable: bit 5 is reserved and never stored
`define CSCW_WIN_EN_MASK 8'hDF
`define CSCW_RESET_BYTE 8'h00
`define CSCW_RESET_FLAGS 4'h0

`endif

// File: shared/cscw_pkg.sv
// types shared by the socket status-change and window enable block
// assumes it is compiled before the design and the bench
`default_nettype none

package cscw_pkg;

  // one register access from the host side, valid for a single cycle
  typedef struct packed {
    logic [11:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } cscw_req_t;

  // card-side status pins, asynchronous to mclk
  typedef struct packed {
    logic card_detect_a;
    logic card_detect_b;
    logic ready;
    logic battery_warning;
    logic card_status_change_signal;
  } cscw_card_t;

  // destinations of the socket status-change request
  typedef struct packed {
    logic [15:0] isa_irq;
    logic smi;
    logic pci_irq;
  } cscw_route_t;

endpackage

`default_nettype wire

// File: src/cscw_sync.sv
// three-stage synchroniser for asynchronous card pins
// assumes one clock mclk and an asynchronous active-high reset
`timescale 1ns/10ps
`default_nettype none

module cscw_sync #(
  parameter int W = 5
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // pins in, filtered levels out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } cscw_sync_state_t;

  cscw_sync_state_t s;
  cscw_sync_state_t next_s;

  // a bit moves only once stages two and three agree, so a glitch that
  // lives one cycle never reaches the flag logic; stage one feeds s2 only
  always_comb begin
    next_s = s;
    next_s.s1 = d;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    for (int i = 0; i < W; i++) begin
      if (s.s2[i] == s.s3[i]) begin
        next_s.q[i] = s.s3[i];
      end
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign q = s.q;

endmodule

`default_nettype wire

// File: src/cscw_socket.sv
// one socket: status-change flags, their routing, and window enables
// assumes host accesses arrive one cycle wide on mclk and card pins are
// asynchronous; window hits come from address decoders on mclk
`timescale 1ns/10ps
`default_nettype none
`include "cscw_map.svh"

// How it works
// R1: select 0000 with diagnostic bit set sends requests to PCI interrupt.
// R2: select 0000, diagnostic clear: no ISA line; PCI only if socket route.
// R3: select 0001 is IRQ1, 0010 is SMI, other codes are that IRQ number.
// R4: bit 3 lets any card-detect line change raise a status change.
// R5: bit 2 lets a ready rising edge on a memory card raise a status change.
// R6: bit 1 lets a battery warning rising edge on a memory card raise a status change.
// R7: bit 0 lets battery dead or card status change signal raise one.
// R8: a disabled window never acknowledges host memory or I/O cycles.
// R9: window enable bit 7 enables I/O window 1; resets disabled.
// R10: window enable bit 6 enables I/O window 0; resets disabled.
// R11: window enable bits 4..0 enable memory windows 4..0; reset 0.
// R12: window enable bit 5 reads 0 and ignores writes.
// R13: window enable at index 06h or 46h, alias 806h, resets 00h.
// R14: I/O window control at 07h or 47h, alias 807h, resets 00h.
// R15: a masked flag reads 0; an enabled active source sets its flag.
// R16: flags clear by read, or by writing 1, as clear mode selects.
// R17: request stands while an enabled flag is set, on the chosen line.
module cscw_socket
  import cscw_pkg::*;
#(
  parameter logic [7:0] SOCKET_BASE = `CSCW_SOCK_A_BASE
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // register port
  input wire cscw_pkg::cscw_req_t req,
  output logic [7:0] rdata,
  output logic rvalid,
  // global control inputs
  input wire logic diag_pci_route,
  input wire logic socket_pci_route,
  input wire logic flag_clear_by_write,
  input wire logic card_is_io,
  // card pins
  input wire cscw_pkg::cscw_card_t card,
  // windows
  input wire logic [7:0] window_hit,
  output logic [7:0] window_ack,
  output logic [7:0] window_enable,
  output logic [7:0] io_window_ctrl,
  // interrupt destinations
  output cscw_pkg::cscw_route_t route
);
  import cscw_pkg::*;

  typedef struct packed {
    logic [7:0] cfg;
    logic [7:0] win;
    logic [7:0] ioc;
    logic [3:0] flags;
    logic [4:0] prev;
    logic [7:0] rdata;
    logic rvalid;
    logic [7:0] ack;
    cscw_route_t route;
  } cscw_state_t;

  cscw_state_t s;
  cscw_state_t next_s;
  logic [4:0] card_s;
  logic [3:0] ev;
  logic [3:0] clr;
  logic [7:0] idx;
  logic mapped;
  logic irq_any;
  logic [3:0] sel;

  cscw_sync #(.W(5)) u_sync (
    .mclk(mclk),
    .reset(reset),
    .d(card),
    .q(card_s)
  );

  // index decode: socket range, or the 8xxh memory alias with its low byte as index whatever the socket base
  always_comb begin
    idx = 8'h00;
    mapped = 1'b0;
    if (req.addr[11:8] == `CSCW_MEM_ALIAS) begin // R13 R14
      idx = req.addr[7:0];
      mapped = 1'b1;
    end else if (req.addr[11:8] == 4'h0 &&
                 req.addr[7:6] == SOCKET_BASE[7:6]) begin
      idx = {2'b00, req.addr[5:0]};
      mapped = 1'b1;
    end
  end

  // source events; ready and battery warning are memory-card only
  always_comb begin
    ev = 4'h0;
    ev[`CSCW_SRC_CD] = (card_s[4] != s.prev[4]) | (card_s[3] != s.prev[3]);
    ev[`CSCW_SRC_READY] = ~card_is_io & card_s[2] & ~s.prev[2];
    ev[`CSCW_SRC_BATWARN] = ~card_is_io & card_s[1] & ~s.prev[1];
    ev[`CSCW_SRC_BATDEAD] = card_s[0] & ~s.prev[0];
  end

  assign sel = s.cfg[`CSCW_SEL_MSB:`CSCW_SEL_LSB];
  assign irq_any = |(s.flags & s.cfg[3:0]); // R17

  // next state: registers, flags, read data, routing and acks
  always_comb begin
    next_s = s;
    next_s.prev = card_s;
    next_s.rvalid = req.rd;
    next_s.rdata = 8'h00; // unmapped reads return zero
    clr = 4'h0;
    if (mapped && req.wr) begin
      case (idx)
        `CSCW_IDX_CONFIG: next_s.cfg = req.wdata;
        `CSCW_IDX_WIN_EN: next_s.win = req.wdata & `CSCW_WIN_EN_MASK; // R12
        `CSCW_IDX_IO_CTRL: next_s.ioc = req.wdata; // R14
        `CSCW_IDX_STATUS: begin
          if (flag_clear_by_write) begin
            clr = req.wdata[3:0]; // R16
          end
        end
        default: next_s.cfg = s.cfg;
      endcase
    end
    if (mapped && req.rd) begin
      case (idx)
        `CSCW_IDX_STATUS: begin
          next_s.rdata = {4'h0, s.flags & s.cfg[3:0]}; // R15
          if (!flag_clear_by_write) begin
            clr = 4'hF; // R16
          end
        end
        `CSCW_IDX_CONFIG: next_s.rdata = s.cfg;
        `CSCW_IDX_WIN_EN: next_s.rdata = s.win;
        `CSCW_IDX_IO_CTRL: next_s.rdata = s.ioc;
        default: next_s.rdata = 8'h00;
      endcase
    end
    // set after clear so a same-cycle event survives; mask by new enables
    next_s.flags = ((s.flags & ~clr) | (ev & s.cfg[3:0]))
                   & next_s.cfg[3:0]; // R4 R5 R6 R7 R15
    // a window only answers when its enable bit is set
    next_s.ack = window_hit & s.win; // R8 R9 R10 R11
    next_s.route = '0;
    if (sel == `CSCW_SEL_NONE) begin
      next_s.route.pci_irq = irq_any & (diag_pci_route | socket_pci_route); // R1 R2
    end else if (sel == `CSCW_SEL_SMI) begin
      next_s.route.smi = irq_any; // R3
    end else begin
      next_s.route.isa_irq[sel] = irq_any; // R3 R17
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      s.cfg <= `CSCW_RESET_BYTE;
      s.win <= `CSCW_RESET_BYTE;
      s.ioc <= `CSCW_RESET_BYTE;
      s.flags <= `CSCW_RESET_FLAGS;
      s.prev <= '0;
      s.rdata <= 8'h00;
      s.rvalid <= 1'b0;
      s.ack <= 8'h00;
      s.route <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign rdata = s.rdata;
  assign rvalid = s.rvalid;
  assign window_ack = s.ack;
  assign window_enable = s.win;
  assign io_window_ctrl = s.ioc;
  assign route = s.route;

  // checks
  logic wr_win;
  logic wr_cfg;
  logic rd_stat;
  assign wr_win = mapped && req.wr && idx == `CSCW_IDX_WIN_EN;
  assign wr_cfg = mapped && req.wr && idx == `CSCW_IDX_CONFIG;
  assign rd_stat = mapped && req.rd && idx == `CSCW_IDX_STATUS;

  property p_reserved;
    @(posedge mclk) disable iff (reset) wr_win |=> !window_enable[5];
  endproperty
  a_reserved: assert property (p_reserved) else $error("bit 5 stored"); // R12

  property p_win_write;
    @(posedge mclk) disable iff (reset)
      wr_win |=> window_enable == ($past(req.wdata) & 8'hDF);
  endproperty
  a_win_write: assert property (p_win_write) else $error("win en"); // R13

  property p_no_ack;
    @(posedge mclk) disable iff (reset)
      (window_hit & ~window_enable) != 8'h00 |=>
        (window_ack & $past(window_hit & ~window_enable)) == 8'h00;
  endproperty
  a_no_ack: assert property (p_no_ack) else $error("ack when off"); // R8

  property p_masked;
    @(posedge mclk) disable iff (reset) (s.flags & ~s.cfg[3:0]) == 4'h0;
  endproperty
  a_masked: assert property (p_masked) else $error("masked flag set"); // R15

  property p_set;
    @(posedge mclk) disable iff (reset)
      (|(ev & s.cfg[3:0])) && !wr_cfg |=> (s.flags & $past(ev)) != 4'h0;
  endproperty
  a_set: assert property (p_set) else $error("event lost"); // R4

  property p_read_clear;
    @(posedge mclk) disable iff (reset)
      rd_stat && !flag_clear_by_write && ev == 4'h0 |=> s.flags == 4'h0;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("no clear"); // R16

  property p_pci;
    @(posedge mclk) disable iff (reset)
      irq_any && sel == 4'h0 && (diag_pci_route || socket_pci_route)
        |=> route.pci_irq && route.isa_irq == 16'h0000;
  endproperty
  a_pci: assert property (p_pci) else $error("pci route"); // R1

  property p_none;
    @(posedge mclk) disable iff (reset)
      sel == 4'h0 && !diag_pci_route && !socket_pci_route
        |=> route == '0;
  endproperty
  a_none: assert property (p_none) else $error("stray route"); // R2

  property p_smi;
    @(posedge mclk) disable iff (reset)
      irq_any && sel == 4'h2 |=> route.smi ##0 !route.isa_irq[2];
  endproperty
  a_smi: assert property (p_smi) else $error("smi route"); // R3

  property p_drop;
    @(posedge mclk) disable iff (reset) !irq_any |=> route == '0;
  endproperty
  a_drop: assert property (p_drop) else $error("request stuck"); // R17

  c_cd: cover property (@(posedge mclk) s.flags[3]);
  c_smi: cover property (@(posedge mclk) route.smi);
  c_ack: cover property (@(posedge mclk) window_ack != 8'h00);

endmodule

`default_nettype wire

// File: test/cscw_card_model.sv
// card side of one socket: five status pins that the bench flips at will
// assumes mclk and reset of the bench; pins change only just after edges
`timescale 1ns/10ps
`default_nettype none

module cscw_card_model
  import cscw_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // one-cycle flip requests, same order as the pin struct
  input wire logic [4:0] flip,
  // pins towards the socket
  output cscw_pkg::cscw_card_t card
);
  // pins hold their level between flips, as a real card would
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      card <= '0;
    end else begin
      card <= card ^ flip;
    end
  end
endmodule

`default_nettype wire

// File: test/test_card_csc_irq_and_window_enable.sv
// self-checking bench of one socket: registers, window gating, routing
// assumes the socket at base 00h and a card model on its pins
`timescale 1ns/10ps
`default_nettype none

module test_card_csc_irq_and_window_enable;
  import cscw_pkg::*;
  logic mclk, reset, diag, sock, clr_wr, rvalid, io;
  cscw_req_t req;
  logic [7:0] rdata, hit, ack, wen, ioc, d, v;
  logic [4:0] flip;
  cscw_card_t card;
  cscw_route_t route;
  int fails, samples_checked, cyc, i;

  cscw_socket cscw_socket_inst (.mclk(mclk), .reset(reset), .req(req),
    .rdata(rdata), .rvalid(rvalid), .diag_pci_route(diag),
    .socket_pci_route(sock), .flag_clear_by_write(clr_wr),
    .card_is_io(io), .card(card), .window_hit(hit), .window_ack(ack),
    .window_enable(wen), .io_window_ctrl(ioc), .route(route));
  cscw_card_model cscw_card_model_inst (.mclk(mclk), .reset(reset),
    .flip(flip), .card(card));

  // free-running 250 MHz clock
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // hang guard: a run this short never needs 20000 cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      results();
    end
  end

  task automatic results();
    if (fails == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic chk_route(input cscw_route_t g, input cscw_route_t e);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // register write: one-cycle strobe taken at the next edge
  task automatic wr(input logic [11:0] a, input logic [7:0] x);
    @(posedge mclk);
    #1 req = {a, 2'b10, x};
    @(posedge mclk);
    #1 req = '0;
  endtask

  // register read: data is only trusted while rvalid stands
  task automatic rd(input logic [11:0] a, output logic [7:0] x);
    @(posedge mclk);
    #1 req = {a, 2'b01, 8'h00};
    @(posedge mclk);
    #1 req = '0;
    x = rvalid ? rdata : 8'hXX;
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // flip card pins, then allow synchroniser, flag and route stages
  task automatic pulse(input logic [4:0] f);
    @(posedge mclk);
    #1 flip = f;
    @(posedge mclk);
    #1 flip = '0;
    wait_n(10);
  endtask

  function automatic cscw_route_t exp_route(input logic [3:0] s,
                                            input logic dg, input logic sk);
    cscw_route_t r;
    r = '0;
    if (s == 4'h0) begin
      r.pci_irq = dg | sk;
    end else if (s == 4'h2) begin
      r.smi = 1'b1;
    end else begin
      r.isa_irq[s] = 1'b1;
    end
    return r;
  endfunction

  // main sequence
  initial begin
    req = '0;
    diag = 1'b0;
    sock = 1'b0;
    clr_wr = 1'b0;
    io = 1'b0;
    hit = '0;
    flip = '0;
    fails = 0;
    samples_checked = 0;
    cyc = 0;
    reset = 1'b1;
    void'($urandom(3));
    repeat (16) @(posedge mclk);
    #1 reset = 1'b0;
    // every register reads 00h after reset, direct and through the alias
    for (i = 4; i < 8; i++) begin
      rd(12'h000 + 12'(i), d);
      chk_byte(d, 8'h00);
      rd(12'h800 + 12'(i), d);
      chk_byte(d, 8'h00);
    end
    // window enables: corner bytes first, then random bytes and hits
    for (i = 0; i < 10; i++) begin
      v = (i == 0) ? 8'hFF : (i == 1) ? 8'h20 : 8'($urandom);
      wr(12'h006, v);
      rd(12'h806, d);
      chk_byte(d, v & 8'hDF);
      chk_byte(wen, v & 8'hDF);
      hit = 8'($urandom);
      wait_n(2);
      chk_byte(ack, hit & v & 8'hDF);
      v = 8'($urandom);
      wr(12'h807, v);
      rd(12'h007, d);
      chk_byte(d, v);
      chk_byte(ioc, v);
    end
    // mid-run reset: enables fall back to 00h and acks stop at once
    wr(12'h006, 8'hFF);
    reset = 1'b1;
    wait_n(2);
    reset = 1'b0;
    wait_n(2);
    chk_byte(wen, 8'h00);
    chk_byte(ioc, 8'h00);
    chk_byte(ack, 8'h00);
    rd(12'h046, d);
    chk_byte(d, 8'h00);
    // a masked card-detect change leaves no flag behind
    wr(12'h005, 8'h00);
    pulse(5'h10);
    rd(12'h004, d);
    chk_byte(d, 8'h00);
    // an enabled change goes to the PCI interrupt by the diagnostic bit
    wr(12'h005, 8'h08);
    diag = 1'b1;
    pulse(5'h08);
    chk_route(route, exp_route(4'h0, 1'b1, 1'b0));
    // every select code, with random routing controls
    for (i = 0; i < 16; i++) begin
      diag = 1'($urandom);
      sock = 1'($urandom);
      wr(12'h005, {4'(i), 4'h8});
      wait_n(3);
      chk_route(route, exp_route(4'(i), diag, sock));
    end
    // read-to-clear mode
    rd(12'h004, d);
    chk_byte(d, 8'h08);
    rd(12'h004, d);
    chk_byte(d, 8'h00);
    wait_n(3);
    chk_route(route, '0);
    // write-one-to-clear mode: reads leave the flags alone
    wr(12'h005, 8'h07);
    pulse(5'h07);
    clr_wr = 1'b1;
    rd(12'h004, d);
    chk_byte(d, 8'h07);
    rd(12'h004, d);
    chk_byte(d, 8'h07);
    wr(12'h004, 8'h05);
    rd(12'h004, d);
    chk_byte(d, 8'h02);
    // falling pins raise nothing; an I/O card keeps only bit 0
    wr(12'h004, 8'h0F);
    pulse(5'h07);
    rd(12'h004, d);
    chk_byte(d, 8'h00);
    io = 1'b1;
    pulse(5'h07);
    rd(12'h004, d);
    chk_byte(d, 8'h01);
    chk_route(route, exp_route(4'h0, diag, sock));
    results();
  end
endmodule

`default_nettype wire
